// ---- rtl/adcc_top.sv ----
// Converter control block: registers, sequencing and result formatting.
// Assumes the analog converter delivers a 10-bit value when sampled at
// conversion end, and a sleep level from outside the core's clock domain.
`default_nettype none
`timescale 1ns/100ps
// Functional notes
// - Channel field selects one of eight inputs.
// - Reference bit picks external pin or supply.
// - Conversion lasts eleven bit periods.
// - Clock select code sets bit period divisor.
// - RC option gives 500 kHz maximum clock.
// - Go bit starts, reads one while busy.
// - Completion clears go, sets flag, interrupt.
// - Clearing go aborts, results keep old value.
// - Abort waits two periods, then acquires.
// - Justify bit picks right or left format.
// - Power bit runs or shuts converter.
// - Analog select bits disable digital pin use.
// - Unimplemented bits read as zero.
// - Hold capacitor never discharged between conversions.
// - RC clock delays start one instruction.
// - Sleep aborts non-RC conversion, power stays.
// - Reset aborts, results are left unchanged.
module adcc_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic sleep_req,
   input wire logic done_int_en,
   input wire logic done_flag_clr,
   input wire logic [9:0] conv_result,
   output logic [2:0] input_channel_field,
   output logic reference_source_bit,
   output logic analog_power,
   output logic sample_enable,
   output logic convert_active,
   output logic convert_bit_tick,
   output logic convert_done_flag,
   output logic convert_irq,
   output logic [7:0] pin_analog_bits,
   output logic [7:0] pin_digital_enable
);
   // Control register fields held separately.
   logic justify_q;
   logic ref_q;
   logic [2:0] chan_q;
   logic go_q;
   logic power_q;
   logic [2:0] csel_q;
   logic [7:0] pinsel_q;
   // Result registers have no reset: device reset leaves them unchanged.
   logic [7:0] res_hi_q;
   logic [7:0] res_lo_q;
   // Sequencer state and bit period counter.
   adcc_pkg::adcc_state_t state_q;
   adcc_pkg::adcc_state_t state_d;
   logic [3:0] per_q;
   logic [2:0] dly_q;
   // Registered outputs.
   logic [7:0] rdata_q;
   logic flag_q;
   logic irq_q;
   logic bit_tick_q;
   logic sample_q;
   // Digital enables kept in their own flop so the pin output is registered.
   logic [7:0] pin_dig_q;
   // Sleep input comes from outside: two-stage synchroniser.
   logic sleep_s1_q;
   logic sleep_s2_q;

   // Write decode.
   wire wr_main = reg_wr && (reg_addr == adcc_pkg::ADDR_CTRL_MAIN);
   wire wr_clk = reg_wr && (reg_addr == adcc_pkg::ADDR_CLK_CFG);
   wire wr_pin = reg_wr && (reg_addr == adcc_pkg::ADDR_PIN_SEL);
   wire go_wr = reg_wdata[adcc_pkg::BIT_GO];
   wire rc_sel = (csel_q[1:0] == 2'b11);
   // Sleep turns the analog part off unless the RC clock is chosen.
   wire sleep_kill = sleep_s2_q && !rc_sel;
   wire run = power_q && !sleep_kill;
   // Power bit as it will stand after this cycle's write.
   wire power_d = wr_main ? reg_wdata[adcc_pkg::BIT_POWER] : power_q;
   wire tick;
   // Start: go written while go was clear, powered and not stopped by sleep; the state is not decoded.
   wire start = wr_main && go_wr && !go_q && power_q && !sleep_kill;
   // Abort: software writes go low while busy, or power/sleep drops.
   wire busy = (state_q == adcc_pkg::ADCC_DELAY) ||
               (state_q == adcc_pkg::ADCC_CONV);
   wire sw_abort = busy && wr_main && !go_wr;
   wire hw_abort = busy && !run;
   wire conv_end = (state_q == adcc_pkg::ADCC_CONV) && tick &&
                   (per_q == adcc_pkg::CONV_BIT_PERIODS - 4'h1);
   wire rec_end = (state_q == adcc_pkg::ADCC_RECOVER) && tick &&
                  (per_q == adcc_pkg::ABORT_BIT_PERIODS - 4'h1);
   wire seq_tick_run = (state_q == adcc_pkg::ADCC_CONV) ||
                       (state_q == adcc_pkg::ADCC_RECOVER);

   // Formatted result for the two justifications.
   wire [7:0] fmt_hi = justify_q ? {6'h00, conv_result[9:8]}
                                 : conv_result[9:2];
   wire [7:0] fmt_lo = justify_q ? conv_result[7:0]
                                 : {conv_result[1:0], 6'h00};

   // Read multiplexer; unimplemented bits are zero, unmapped reads zero.
   wire [7:0] main_view = {justify_q, ref_q, 1'b0, chan_q, go_q, power_q};
   wire [7:0] rd_mux =
      (reg_addr == adcc_pkg::ADDR_CTRL_MAIN) ? main_view :
      (reg_addr == adcc_pkg::ADDR_CLK_CFG) ? {1'b0, csel_q, 4'h0} :
      (reg_addr == adcc_pkg::ADDR_PIN_SEL) ? pinsel_q :
      (reg_addr == adcc_pkg::ADDR_RES_UPPER) ? res_hi_q :
      (reg_addr == adcc_pkg::ADDR_RES_LOWER) ? res_lo_q : 8'h00;

   // Bit period divider shared by conversion and abort recovery. An abort
   // restarts it, so recovery gets two whole bit periods, not a partial one.
   adcc_tick_gen u_tick (
      .clk(clk),
      .rst_n(rst_n),
      .run(seq_tick_run && run && !sw_abort && !hw_abort),
      .sel(csel_q),
      .tick(tick)
   );

   // Synchronise the sleep level before any logic looks at it.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sleep_s1_q <= 1'b0;
         sleep_s2_q <= 1'b0;
      end
      else
      begin
         sleep_s1_q <= sleep_req;
         sleep_s2_q <= sleep_s1_q;
      end
   end

   // Next state of the sequencer.
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         adcc_pkg::ADCC_IDLE:
         begin
            // With the RC clock the start waits one instruction.
            if (start)
               state_d = rc_sel ? adcc_pkg::ADCC_DELAY
                                : adcc_pkg::ADCC_CONV;
         end
         adcc_pkg::ADCC_DELAY:
         begin
            if (sw_abort || hw_abort)
               state_d = adcc_pkg::ADCC_RECOVER;
            else if (dly_q == adcc_pkg::INSTR_CYCLES - 3'h1)
               state_d = adcc_pkg::ADCC_CONV;
         end
         adcc_pkg::ADCC_CONV:
         begin
            if (sw_abort || hw_abort)
               state_d = adcc_pkg::ADCC_RECOVER;
            else if (conv_end)
               state_d = adcc_pkg::ADCC_IDLE;
         end
         adcc_pkg::ADCC_RECOVER:
         begin
            // Powered-down recovery has no clock; drop straight to idle.
            if (rec_end || !run)
               state_d = adcc_pkg::ADCC_IDLE;
         end
         default: state_d = adcc_pkg::ADCC_IDLE;
      endcase
   end

   // Sequencer state, bit period and instruction delay counters.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_q <= adcc_pkg::ADCC_IDLE;
         per_q <= 4'h0;
         dly_q <= 3'h0;
      end
      else
      begin
         state_q <= state_d;
         if (state_d != state_q)
            per_q <= 4'h0;
         else if (tick)
            per_q <= per_q + 4'h1;
         dly_q <= (state_q == adcc_pkg::ADCC_DELAY) ? dly_q + 3'h1 : 3'h0;
      end
   end

   // Main control register; hardware clears go on completion or abort.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         justify_q <= adcc_pkg::RST_CTRL_MAIN[adcc_pkg::BIT_JUSTIFY];
         ref_q <= adcc_pkg::RST_CTRL_MAIN[adcc_pkg::BIT_REF];
         chan_q <= adcc_pkg::RST_CTRL_MAIN[adcc_pkg::BIT_CHAN_LO +: 3];
         power_q <= adcc_pkg::RST_CTRL_MAIN[adcc_pkg::BIT_POWER];
         go_q <= adcc_pkg::RST_CTRL_MAIN[adcc_pkg::BIT_GO];
      end
      else
      begin
         if (wr_main)
         begin
            justify_q <= reg_wdata[adcc_pkg::BIT_JUSTIFY];
            ref_q <= reg_wdata[adcc_pkg::BIT_REF];
            chan_q <= reg_wdata[adcc_pkg::BIT_CHAN_LO +: 3];
            // Sleep turns the analog part off but the bit stays set.
            power_q <= reg_wdata[adcc_pkg::BIT_POWER];
         end
         if (start)
            go_q <= 1'b1;
         else if (conv_end || sw_abort || hw_abort)
            go_q <= 1'b0;
         else if (wr_main && !go_wr)
            go_q <= 1'b0;
      end
   end

   // Clock configuration and analog pin select registers.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         csel_q <= adcc_pkg::RST_CLK_SEL;
         pinsel_q <= adcc_pkg::RST_PIN_SEL;
         pin_dig_q <= ~adcc_pkg::RST_PIN_SEL;
      end
      else
      begin
         if (wr_clk)
            csel_q <= reg_wdata[adcc_pkg::BIT_CSEL_LO +: 3];
         if (wr_pin)
         begin
            pinsel_q <= reg_wdata;
            pin_dig_q <= ~reg_wdata;
         end
      end
   end

   // Results load only on a finished conversion, never on an abort, and
   // never on a reset edge, so a reset leaves them untouched.
   always_ff @(posedge clk)
   begin
      if (rst_n && conv_end && !sw_abort && !hw_abort)
      begin
         res_hi_q <= fmt_hi;
         res_lo_q <= fmt_lo;
      end
   end

   // Done flag: completion sets it and wins over a clear in that cycle.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         flag_q <= 1'b0;
         irq_q <= 1'b0;
      end
      else
      begin
         if (conv_end && !sw_abort && !hw_abort)
            flag_q <= 1'b1;
         else if (done_flag_clr)
            flag_q <= 1'b0;
         irq_q <= done_int_en && (flag_q ||
                  (conv_end && !sw_abort && !hw_abort));
      end
   end

   // Registered outputs toward the analog front end and the bus.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rdata_q <= 8'h00;
         bit_tick_q <= 1'b0;
         sample_q <= 1'b0;
      end
      else
      begin
         rdata_q <= reg_rd ? rd_mux : 8'h00;
         bit_tick_q <= tick && (state_q == adcc_pkg::ADCC_CONV);
         // Acquisition runs whenever powered and idle, so the hold
         // capacitor tracks the channel and is never discharged. It
         // stops as go is set, also before an RC-delayed start, and uses
         // the next power bit so it never outlives a power-off write.
         sample_q <= power_d && !sleep_kill &&
                     (state_d == adcc_pkg::ADCC_IDLE);
      end
   end

   assign reg_rdata = rdata_q;
   assign input_channel_field = chan_q;
   assign reference_source_bit = ref_q;
   assign analog_power = power_q;
   assign sample_enable = sample_q;
   assign convert_active = go_q;
   assign convert_bit_tick = bit_tick_q;
   assign convert_done_flag = flag_q;
   assign convert_irq = irq_q;
   assign pin_analog_bits = pinsel_q;
   assign pin_digital_enable = pin_dig_q;
endmodule : adcc_top
`default_nettype wire

// ---- common/adcc_pkg.sv ----
// Package for the converter control block: register map, field positions,
// reset values, sequencer states and timing constants.
// Assumes a 40 MHz core clock and an 8-bit register port.
`default_nettype none
package adcc_pkg;
   // Register offsets on the plain register port.
   localparam logic [7:0] ADDR_CTRL_MAIN = 8'h1F;
   localparam logic [7:0] ADDR_RES_UPPER = 8'h1E;
   localparam logic [7:0] ADDR_PIN_SEL = 8'h91;
   localparam logic [7:0] ADDR_RES_LOWER = 8'h9E;
   localparam logic [7:0] ADDR_CLK_CFG = 8'h9F;
   // Field positions in the main control register.
   localparam int BIT_POWER = 0;
   localparam int BIT_GO = 1;
   localparam int BIT_CHAN_LO = 2;
   localparam int BIT_REF = 6;
   localparam int BIT_JUSTIFY = 7;
   // Field position of the clock select in the clock config register.
   localparam int BIT_CSEL_LO = 4;
   // Reset values.
   localparam logic [7:0] RST_CTRL_MAIN = 8'h00;
   localparam logic [2:0] RST_CLK_SEL = 3'h0;
   localparam logic [7:0] RST_PIN_SEL = 8'hFF;
   // Writable masks; unimplemented bits read as zero.
   localparam logic [7:0] MASK_CTRL_MAIN = 8'hDF;
   // Conversion length and abort recovery in bit periods.
   localparam logic [3:0] CONV_BIT_PERIODS = 4'hB;
   localparam logic [3:0] ABORT_BIT_PERIODS = 4'h2;
   // Internal RC option: at most 500 kHz, so at least 80 cycles at 40 MHz.
   localparam int CLK_MHZ = 40;
   localparam int RC_MAX_KHZ = 500;
   localparam int RC_DIV = (CLK_MHZ * 1000) / RC_MAX_KHZ;
   // One instruction cycle is four oscillator periods.
   localparam logic [2:0] INSTR_CYCLES = 3'h4;
   // Converter sequencing states, one-hot.
   typedef enum logic [3:0] {
      ADCC_IDLE = 4'h1,
      ADCC_DELAY = 4'h2,
      ADCC_CONV = 4'h4,
      ADCC_RECOVER = 4'h8
   } adcc_state_t;
endpackage : adcc_pkg
`default_nettype wire

// ---- rtl/adcc_tick_gen.sv ----
// Bit period tick generator for the converter control block.
// Assumes a single clock; produces a one-cycle enable per bit period.
`default_nettype none
`timescale 1ns/100ps
module adcc_tick_gen (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic [2:0] sel,
   output logic tick
);
   // Free counter; restarted whenever the sequencer is idle.
   logic [6:0] cnt_q;
   logic [6:0] limit;

   // Divisor minus one for each select code; x11 is the RC option.
   assign limit = (sel[1:0] == 2'b11) ? 7'(adcc_pkg::RC_DIV - 1) :
                  (sel == 3'b000) ? 7'h01 :
                  (sel == 3'b100) ? 7'h03 :
                  (sel == 3'b001) ? 7'h07 :
                  (sel == 3'b101) ? 7'h0F :
                  (sel == 3'b010) ? 7'h1F : 7'h3F;
   assign tick = run && (cnt_q == limit);

   // Count up to the limit and wrap.
   always_ff @(posedge clk)
   begin
      if (!rst_n || !run || tick)
         cnt_q <= 7'h00;
      else
         cnt_q <= cnt_q + 7'h01;
   end
endmodule : adcc_tick_gen
`default_nettype wire

// ---- dv/adcc_asserts.sv ----
// Checker for the converter control block: port relations over time.
// Assumes it is bound into adcc_top and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module adcc_asserts (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic done_int_en,
   input wire logic analog_power,
   input wire logic sample_enable,
   input wire logic convert_active,
   input wire logic convert_bit_tick,
   input wire logic convert_done_flag,
   input wire logic convert_irq,
   input wire logic [7:0] pin_analog_bits,
   input wire logic [7:0] pin_digital_enable
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // A write to the main control register.
   wire logic main_wr = reg_wr && (reg_addr == adcc_pkg::ADDR_CTRL_MAIN);
   // Ticks seen in the current conversion; held one cycle past its end.
   logic [3:0] tick_cnt_q;
   wire logic [3:0] tick_cnt_d = convert_active ?
      tick_cnt_q + {3'h0, convert_bit_tick} : 4'h0;
   // Counter clears in reset so a mid-run reset starts a fresh count.
   always_ff @(posedge clk) tick_cnt_q <= rst_n ? tick_cnt_d : 4'h0;

   a_go_from_write: assert property (
      $rose(convert_active) |->
      $past(main_wr && reg_wdata[adcc_pkg::BIT_GO]))
      else $error("go bit rose without a go write");
   a_go_needs_power: assert property (
      $rose(convert_active) |-> analog_power)
      else $error("conversion started while powered off");
   a_done_clears_go: assert property (
      $rose(convert_done_flag) |-> $fell(convert_active))
      else $error("done flag set without go clearing");
   a_eleven_ticks: assert property (
      $rose(convert_done_flag) |-> tick_cnt_q inside {[4'hA:4'hB]})
      else $error("conversion length in bit periods is wrong");
   // The request follows the enable a cycle late, and comes with the flag
   // in the cycle that sets it.
   a_irq_follows_flag: assert property (
      convert_irq == ($past(done_int_en) &&
      ($past(convert_done_flag) || $rose(convert_done_flag))))
      else $error("interrupt request does not follow flag and enable");
   a_abort_recovers: assert property (
      main_wr && convert_active && !reg_wdata[adcc_pkg::BIT_GO] |=>
      (!convert_active && !sample_enable && !convert_done_flag) [*3])
      else $error("abort did not stop and wait");
   a_sample_idle: assert property (
      sample_enable |-> analog_power && !convert_active)
      else $error("acquiring while off or converting");
   a_pin_inverse: assert property (
      pin_digital_enable == ~pin_analog_bits)
      else $error("digital enables are not the inverse of analog bits");
   a_rdata_quiet: assert property (
      !$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_main_unimpl: assert property (
      $past(reg_rd && reg_addr == adcc_pkg::ADDR_CTRL_MAIN) |->
      !reg_rdata[5])
      else $error("main control bit 5 reads one");
   a_cfg_unimpl: assert property (
      $past(reg_rd && reg_addr == adcc_pkg::ADDR_CLK_CFG) |->
      reg_rdata[7] == 1'b0 && reg_rdata[3:0] == 4'h0)
      else $error("clock config unused bits read one");
   c_conv_done: cover property ($rose(convert_done_flag));
   c_abort: cover property (main_wr && convert_active && !reg_wdata[1]);
   c_irq: cover property ($rose(convert_irq));
endmodule : adcc_asserts
`default_nettype wire

// ---- dv/adcc_analog_model.sv ----
// Behavioural far side: sample-and-hold and converter value source.
// Assumes the control block samples conv_result at conversion end.
`timescale 1ns/100ps
`default_nettype none
module adcc_analog_model (
   input wire logic clk,
   input wire logic [2:0] input_channel_field,
   input wire logic reference_source_bit,
   input wire logic analog_power,
   input wire logic sample_enable,
   output logic [9:0] conv_result
);
   // Each channel and reference gives a distinct level.
   wire logic [9:0] level = {reference_source_bit, input_channel_field,
      input_channel_field, 3'h5};
   // The hold capacitor keeps its charge between acquisitions.
   logic [9:0] held_q = 10'h000;
   always_ff @(posedge clk) if (sample_enable) held_q <= level;
   // Powered off, the value is meaningless, so it shows the inverse.
   assign conv_result = analog_power ? held_q : ~held_q;
endmodule : adcc_analog_model
`default_nettype wire

// ---- dv/adcc_tb_top.sv ----
// Testbench for the converter control block: register port sequences.
// Assumes the analog model and checker files compile before this one.
`timescale 1ns/100ps
`default_nettype none
module adcc_tb_top;
   logic clk, rst_n, reg_wr, reg_rd, sleep_req, done_int_en, done_flag_clr;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, pin_analog_bits;
   logic [7:0] pin_digital_enable;
   logic [9:0] conv_result, last_r;
   logic [2:0] input_channel_field;
   logic reference_source_bit, analog_power, sample_enable, convert_active;
   logic convert_bit_tick, convert_done_flag, convert_irq;
   int fails = 0, comparisons = 0, cyc = 0, t0;
   // Clock select codes and their divisors in core clocks.
   logic [2:0] codes [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
   int divs [8] = '{2, 4, 8, 16, 32, 64, adcc_pkg::RC_DIV, adcc_pkg::RC_DIV};
   adcc_top dut_u (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .sleep_req, .done_int_en, .done_flag_clr, .conv_result,
      .input_channel_field, .reference_source_bit, .analog_power,
      .sample_enable, .convert_active, .convert_bit_tick, .convert_done_flag,
      .convert_irq, .pin_analog_bits, .pin_digital_enable);
   adcc_analog_model model_u (.clk, .input_channel_field,
      .reference_source_bit, .analog_power, .sample_enable, .conv_result);
   // 40 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Cycle count doubles as the hang guard.
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         fails++;
         results();
      end
   end
   task automatic results();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results
   task automatic check(input string name, input logic [15:0] seen,
      input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe.
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 check("rdata", reg_rdata, exp);
   endtask : chk_rd
   // Both result registers against the last completed value.
   task automatic chk_res(input logic j);
      chk_rd(adcc_pkg::ADDR_RES_UPPER, j ? {6'h00, last_r[9:8]} :
         last_r[9:2]);
      chk_rd(adcc_pkg::ADDR_RES_LOWER, j ? last_r[7:0] :
         {last_r[1:0], 6'h00});
   endtask : chk_res
   task automatic wait_until(input logic want, input int lim);
      while (((want ? sample_enable : convert_active) !== want) &&
         (cyc - t0 < lim))
      begin
         @(posedge clk);
         #1;
      end
   endtask : wait_until
   // One full conversion with a given clock code, channel and format.
   task automatic conv(input int i, input logic j);
      logic [7:0] m;
      m = {j, i[0], 1'b0, i[2:0], 2'b01};
      wr(adcc_pkg::ADDR_CLK_CFG, {1'b0, codes[i], 4'h0});
      done_int_en <= i[0];
      wr(adcc_pkg::ADDR_CTRL_MAIN, m);
      repeat (4) @(posedge clk);
      // The RC clock is only used with the core asleep; it keeps running.
      sleep_req <= (codes[i][1:0] == 2'b11);
      check("chan", input_channel_field, i[2:0]);
      check("ref", reference_source_bit, i[0]);
      wr(adcc_pkg::ADDR_CTRL_MAIN, m | 8'h02);
      t0 = cyc;
      chk_rd(adcc_pkg::ADDR_CTRL_MAIN, m | 8'h02);
      wait_until(1'b0, 4000);
      check("len", cyc - t0 >= 11 * divs[i] &&
         cyc - t0 <= 12 * divs[i] + 6, 1);
      check("flag", convert_done_flag, 1);
      @(posedge clk);
      sleep_req <= 1'b0;
      #1 check("irq", convert_irq, i[0]);
      last_r = {i[0], i[2:0], i[2:0], 3'h5};
      chk_rd(adcc_pkg::ADDR_CTRL_MAIN, m);
      chk_res(j);
      @(posedge clk);
      done_flag_clr <= 1'b1;
      @(posedge clk);
      done_flag_clr <= 1'b0;
      #1 check("flag_clr", convert_done_flag, 0);
   endtask : conv
   initial
   begin
      {rst_n, reg_wr, reg_rd, sleep_req, done_int_en, done_flag_clr} = 6'h00;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      chk_rd(adcc_pkg::ADDR_CTRL_MAIN, 8'h00);
      chk_rd(adcc_pkg::ADDR_CLK_CFG, 8'h00);
      chk_rd(adcc_pkg::ADDR_PIN_SEL, 8'hFF);
      chk_rd(8'h00, 8'h00);
      wr(adcc_pkg::ADDR_CTRL_MAIN, 8'hFC);
      chk_rd(adcc_pkg::ADDR_CTRL_MAIN, 8'hDC);
      wr(adcc_pkg::ADDR_CLK_CFG, 8'hFF);
      chk_rd(adcc_pkg::ADDR_CLK_CFG, 8'h70);
      wr(adcc_pkg::ADDR_PIN_SEL, 8'hA5);
      chk_rd(adcc_pkg::ADDR_PIN_SEL, 8'hA5);
      check("digital", pin_digital_enable, 8'h5A);
      for (int i = 0; i < 8; i++)
         conv(i, i[1]);
      // Abort mid-run on the channel already acquired; divide by 64 is
      // the only divided clock giving a 1.6 us bit period at 40 MHz.
      wr(adcc_pkg::ADDR_CLK_CFG, 8'h60);
      wr(adcc_pkg::ADDR_CTRL_MAIN, 8'hDF);
      repeat (20) @(posedge clk);
      wr(adcc_pkg::ADDR_CTRL_MAIN, 8'hDD);
      t0 = cyc;
      #1 check("abort", convert_active, 0);
      wait_until(1'b1, 1000);
      check("recover", cyc - t0 >= 126 && cyc - t0 <= 198, 1);
      check("no_flag", convert_done_flag, 0);
      chk_res(1'b1);
      // A go write is refused while powered off.
      wr(adcc_pkg::ADDR_CTRL_MAIN, 8'h80);
      wr(adcc_pkg::ADDR_CTRL_MAIN, 8'h82);
      #1 check("refused", convert_active, 0);
      // Sleep stops a divided-clock conversion but keeps the power bit.
      wr(adcc_pkg::ADDR_CTRL_MAIN, 8'h81);
      repeat (4) @(posedge clk);
      wr(adcc_pkg::ADDR_CTRL_MAIN, 8'h83);
      repeat (10) @(posedge clk);
      sleep_req <= 1'b1;
      repeat (8) @(posedge clk);
      sleep_req <= 1'b0;
      #1 check("sleep_stop", convert_active, 0);
      check("sleep_pwr", analog_power, 1);
      chk_res(1'b1);
      // Reset in mid-run keeps the results.
      wr(adcc_pkg::ADDR_CTRL_MAIN, 8'h83);
      rst_n <= 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      chk_rd(adcc_pkg::ADDR_CTRL_MAIN, 8'h00);
      check("pins", pin_analog_bits, 8'hFF);
      wr(adcc_pkg::ADDR_CTRL_MAIN, 8'h80);
      chk_res(1'b1);
      results();
   end
endmodule : adcc_tb_top
bind adcc_top adcc_asserts chk_u (.clk, .rst_n, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .done_int_en, .analog_power, .sample_enable,
   .convert_active, .convert_bit_tick, .convert_done_flag, .convert_irq,
   .pin_analog_bits, .pin_digital_enable);
`default_nettype wire
